// *** darc_pkg.sv ***
// Package for the reference, alarm and range configuration register bank.
// Assumes a byte-addressed Avalon-MM slave port with 32-bit data words.
package darc_pkg;

    // Register indices; the byte address is four times the index
    localparam logic [7:0] DARC_IDX_CH5_RANGE  = 8'h1A;
    localparam logic [7:0] DARC_IDX_REF_SRC    = 8'h1B;
    localparam logic [7:0] DARC_IDX_FAULT_CFG  = 8'h1C;
    localparam logic [7:0] DARC_IDX_CH0_FILTER = 8'h1D;

    // Avalon byte address width in bits
    localparam int unsigned DARC_ADDR_W = 8;

    // Channel 5 range setup fields
    localparam int unsigned DARC_CH5_SCALE_LSB = 2;
    localparam int unsigned DARC_CH5_SCALE_W   = 6;
    localparam int unsigned DARC_CH5_RANGE_BIT = 0;
    localparam logic [7:0]  DARC_CH5_RANGE_RST = 8'h00;

    // Reference source select fields
    localparam int unsigned DARC_REF_RES_BIT  = 2;
    localparam int unsigned DARC_REF_VSEL_LSB = 0;
    localparam int unsigned DARC_REF_VSEL_W   = 2;
    localparam logic [7:0]  DARC_REF_SRC_RST  = 8'h00;

    // Voltage reference schemes
    typedef enum logic [1:0] {
        DARC_VREF_EXT_2V5     = 2'h0,
        DARC_VREF_INT_OUT_ON  = 2'h1,
        DARC_VREF_EXT_1V25    = 2'h2,
        DARC_VREF_INT_OUT_OFF = 2'h3
    } darc_vref_t;

    // Fault signal configuration fields
    localparam int unsigned DARC_CFG_CRC_MASK_BIT  = 7;
    localparam int unsigned DARC_CFG_RES_MASK_BIT  = 6;
    localparam int unsigned DARC_CFG_NEG_MASK_BIT  = 5;
    localparam int unsigned DARC_CFG_OT_MASK_BIT   = 4;
    localparam int unsigned DARC_CFG_WARN_MASK_BIT = 3;
    localparam int unsigned DARC_CFG_CRC_EN_BIT    = 2;
    localparam int unsigned DARC_CFG_TSD_EN_BIT    = 1;
    localparam int unsigned DARC_CFG_OD_EN_BIT     = 0;
    localparam logic [7:0]  DARC_FAULT_CFG_RST     = 8'h06;

    // Channel 0 filter resistor field and codes
    localparam int unsigned DARC_FILT_W       = 4;
    localparam logic [7:0]  DARC_CH0_FILT_RST = 8'h00;
    localparam logic [3:0]  DARC_FILT_60R     = 4'h0;
    localparam logic [3:0]  DARC_FILT_5K6     = 4'h5;
    localparam logic [3:0]  DARC_FILT_11K2    = 4'h6;
    localparam logic [3:0]  DARC_FILT_22K2    = 4'h7;
    localparam logic [3:0]  DARC_FILT_44K4    = 4'h8;
    localparam logic [3:0]  DARC_FILT_104K    = 4'h9;

    // Fault input positions
    localparam int unsigned DARC_NFAULT     = 5;
    localparam int unsigned DARC_FLT_CRC    = 0;
    localparam int unsigned DARC_FLT_RES    = 1;
    localparam int unsigned DARC_FLT_NEG    = 2;
    localparam int unsigned DARC_FLT_OT     = 3;
    localparam int unsigned DARC_FLT_WARN   = 4;

endpackage : darc_pkg

// *** darc_sync2.sv ***
// Two flip-flop synchroniser for a group of asynchronous level inputs.
// Assumes each bit is an independent level; no bus coherence is implied.
`timescale 1ns/100ps
module darc_sync2 #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clock_i,
    input  wire logic             resetn_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } darc_sync_state_t;

    darc_sync_state_t state_reg;
    darc_sync_state_t state_next;

    // First stage feeds only the second stage
    always_comb begin
        state_next        = state_reg;
        state_next.meta   = async_i;
        state_next.stable = state_reg.meta;
    end

    // State register
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync_o = state_reg.stable;

endmodule : darc_sync2

// *** darc_regs.sv ***
// Configuration register bank: channel 5 range, reference source, fault signal
// configuration and channel 0 filter resistor, plus the alarm pin logic.
// Assumes an Avalon-MM master on clock_i and fault levels arriving from
// analog monitors outside this clock domain.
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/100ps

// How it works
// R1 - Channel 5 range register bits 7:2 hold a read/write scale factor that resets to zero.
// R2 - Channel 5 range register bit 0 picks 0-45 mA when clear and 0-100 mA when set, reset zero.
// R3 - Reference register bit 2 picks the internal resistor when clear, external when set.
// R4 - Reference register bits 1:0 pick ext 2.5 V, int 1.25 V out on, ext 1.25 V, int out off.
// R5 - Fault config bit 7 set keeps background CRC errors off the alarm pin.
// R6 - Fault config bit 6 set keeps reference resistor faults off the alarm pin.
// R7 - Fault config bit 5 set keeps the channel 0 negative monitor voltage off the alarm pin.
// R8 - Fault config bit 4 set keeps over-temperature faults off the alarm pin.
// R9 - Fault config bit 3 set keeps over-temperature warnings off the alarm pin.
// R10 - Fault config bit 2 enables background CRC checking and resets to one.
// R11 - Fault config bit 1 enables thermal shutdown on over-temperature and resets to one.
// R12 - Fault config bit 0 makes the alarm pin open-drain when set, push-pull when clear.
// R13 - Channel 0 filter register bits 3:0 hold the read/write filter resistor code.
// R14 - Filter codes 0,5,6,7,8,9 select 60 R, 5.6 k, 11.2 k, 22.2 k, 44.4 k and 104 k.
// R15 - The alarm is active while any present condition has its mask clear; a CRC error counts only while bit 2 is set.
module darc_regs
    import darc_pkg::*;
(
    input  wire logic                      clock_i,
    input  wire logic                      resetn_i,
    // Avalon-MM slave
    input  wire logic [darc_pkg::DARC_ADDR_W-1:0] avs_address_i,
    input  wire logic                      avs_read_i,
    input  wire logic                      avs_write_i,
    input  wire logic [31:0]               avs_writedata_i,
    input  wire logic [3:0]                avs_byteenable_i,
    output logic      [31:0]               avs_readdata_o,
    output logic                           avs_waitrequest_o,
    // Fault condition levels from monitors, asynchronous
    input  wire logic                      crc_error_i,
    input  wire logic                      ref_resistor_fault_i,
    input  wire logic                      ch_zero_negative_i,
    input  wire logic                      over_temp_fault_i,
    input  wire logic                      over_temp_warning_i,
    // Configuration towards the analog core
    output logic [darc_pkg::DARC_CH5_SCALE_W-1:0] ch_five_scale_factor_o,
    output logic                           ch_five_range_select_o,
    output logic                           ref_external_resistor_o,
    output darc_pkg::darc_vref_t           ref_voltage_select_o,
    output logic                           ref_internal_enable_o,
    output logic                           ref_output_enable_o,
    output logic [darc_pkg::DARC_FILT_W-1:0] ch_zero_filter_res_code_o,
    output logic                           ch_zero_filter_code_valid_o,
    output logic                           background_crc_enable_o,
    output logic                           thermal_shutdown_o,
    // Alarm pin, active low; oe_n low while driving
    output logic                           alarm_n_out_o,
    output logic                           alarm_n_oe_n_o
);

    typedef struct packed {
        logic [7:0]                  ch5_range;
        logic [7:0]                  ref_src;
        logic [7:0]                  fault_cfg;
        logic [7:0]                  ch0_filter;
        logic                        wait_rq;
        logic [31:0]                 rdata;
        logic                        alarm;
        logic                        tsd;
        logic                        alarm_out;
        logic                        alarm_oe_n;
        logic [DARC_NFAULT-1:0]      faults;
        logic                        ref_out_en;
        logic                        filt_valid;
    } darc_state_t;

    localparam darc_state_t DARC_STATE_RST = '{
        ch5_range:  DARC_CH5_RANGE_RST,
        ref_src:    DARC_REF_SRC_RST,
        fault_cfg:  DARC_FAULT_CFG_RST,
        ch0_filter: DARC_CH0_FILT_RST,
        wait_rq:    1'b1,
        rdata:      32'h0000_0000,
        alarm:      1'b0,
        tsd:        1'b0,
        alarm_out:  1'b1,
        alarm_oe_n: 1'b0,
        faults:     '0,
        ref_out_en: 1'b0,
        filt_valid: 1'b1
    };

    darc_state_t            state_reg;
    darc_state_t            state_next;
    logic [DARC_NFAULT-1:0] fault_raw;
    logic [DARC_NFAULT-1:0] fault_sync;
    logic [DARC_NFAULT-1:0] fault_mask;
    logic                   req;
    logic [7:0]             idx;
    logic                   aligned;
    logic [7:0]             rd_byte;
    logic                   alarm_now;

    // Gather and synchronise the monitor levels
    assign fault_raw = {over_temp_warning_i, over_temp_fault_i, ch_zero_negative_i,
                        ref_resistor_fault_i, crc_error_i};

    darc_sync2 #(
        .WIDTH (DARC_NFAULT)
    ) u_fault_sync (
        .clock_i  (clock_i),
        .resetn_i (resetn_i),
        .async_i  (fault_raw),
        .sync_o   (fault_sync)
    );

    // Address decode: word index from byte address
    assign req     = avs_read_i | avs_write_i;
    assign idx     = {2'b00, avs_address_i[DARC_ADDR_W-1:2]};
    assign aligned = (avs_address_i[1:0] == 2'b00);

    // Read multiplexer; unmapped and reserved bits read zero
    always_comb begin
        rd_byte = 8'h00;
        if (aligned) begin
            unique case (idx)
                DARC_IDX_CH5_RANGE:  rd_byte = state_reg.ch5_range;
                DARC_IDX_REF_SRC:    rd_byte = state_reg.ref_src;
                DARC_IDX_FAULT_CFG:  rd_byte = state_reg.fault_cfg;
                DARC_IDX_CH0_FILTER: rd_byte = state_reg.ch0_filter;
                default:             rd_byte = 8'h00;
            endcase
        end
    end

    // Mask bits lined up with fault positions
    always_comb begin
        fault_mask                = '0;
        fault_mask[DARC_FLT_CRC]  = state_reg.fault_cfg[DARC_CFG_CRC_MASK_BIT];   // R5
        fault_mask[DARC_FLT_RES]  = state_reg.fault_cfg[DARC_CFG_RES_MASK_BIT];   // R6
        fault_mask[DARC_FLT_NEG]  = state_reg.fault_cfg[DARC_CFG_NEG_MASK_BIT];   // R7
        fault_mask[DARC_FLT_OT]   = state_reg.fault_cfg[DARC_CFG_OT_MASK_BIT];    // R8
        fault_mask[DARC_FLT_WARN] = state_reg.fault_cfg[DARC_CFG_WARN_MASK_BIT];  // R9
    end

    // Any unmasked present condition raises the alarm
    assign alarm_now = |(state_reg.faults & ~fault_mask);  // R15

    // Next-state logic
    always_comb begin
        state_next = state_reg;

        // Bus handshake: one wait cycle, then waitrequest low for one cycle
        if (req && state_reg.wait_rq) begin
            state_next.wait_rq = 1'b0;
            state_next.rdata   = avs_read_i ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end else begin
            state_next.wait_rq = 1'b1;
        end

        // Writes land on the edge where waitrequest is seen low
        if (avs_write_i && !state_reg.wait_rq && aligned && avs_byteenable_i[0]) begin
            unique case (idx)
                DARC_IDX_CH5_RANGE: begin
                    state_next.ch5_range = {avs_writedata_i[7:2], 1'b0,
                                            avs_writedata_i[0]};  // R1 R2
                end
                DARC_IDX_REF_SRC: begin
                    state_next.ref_src = {5'h00, avs_writedata_i[2:0]};  // R3 R4
                end
                DARC_IDX_FAULT_CFG: begin
                    state_next.fault_cfg = avs_writedata_i[7:0];  // R10 R11 R12
                end
                DARC_IDX_CH0_FILTER: begin
                    state_next.ch0_filter = {4'h0, avs_writedata_i[3:0]};  // R13
                end
                default: begin
                    state_next.rdata = state_reg.rdata;  // Unmapped write ignored
                end
            endcase
        end

        // Decoded flags registered together with the fields they follow
        state_next.ref_out_en = (state_next.ref_src[1:0] == DARC_VREF_INT_OUT_ON);  // R4
        state_next.filt_valid = (state_next.ch0_filter[3:0] == DARC_FILT_60R)
                              | (state_next.ch0_filter[3:0] == DARC_FILT_5K6)
                              | (state_next.ch0_filter[3:0] == DARC_FILT_11K2)
                              | (state_next.ch0_filter[3:0] == DARC_FILT_22K2)
                              | (state_next.ch0_filter[3:0] == DARC_FILT_44K4)
                              | (state_next.ch0_filter[3:0] == DARC_FILT_104K);  // R14

        // CRC errors only count while background checking runs
        state_next.faults = fault_sync;
        state_next.faults[DARC_FLT_CRC] = fault_sync[DARC_FLT_CRC]
                                        & state_reg.fault_cfg[DARC_CFG_CRC_EN_BIT];  // R10
        state_next.alarm = alarm_now;  // R15

        // Shutdown follows an over-temperature fault when enabled
        state_next.tsd = state_reg.faults[DARC_FLT_OT]
                       & state_reg.fault_cfg[DARC_CFG_TSD_EN_BIT];  // R11

        // Pin driver: open-drain releases when idle, push-pull drives high
        if (state_reg.fault_cfg[DARC_CFG_OD_EN_BIT]) begin
            state_next.alarm_out  = 1'b0;  // R12
            state_next.alarm_oe_n = ~alarm_now;  // R12
        end else begin
            state_next.alarm_out  = ~alarm_now;  // R12
            state_next.alarm_oe_n = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg <= DARC_STATE_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from state flip-flops
    assign avs_readdata_o         = state_reg.rdata;
    assign avs_waitrequest_o      = state_reg.wait_rq;
    assign ch_five_scale_factor_o = state_reg.ch5_range[DARC_CH5_SCALE_LSB +: DARC_CH5_SCALE_W]; // R1
    assign ch_five_range_select_o = state_reg.ch5_range[DARC_CH5_RANGE_BIT];  // R2
    assign ref_external_resistor_o = state_reg.ref_src[DARC_REF_RES_BIT];  // R3
    assign ref_voltage_select_o   = darc_vref_t'(state_reg.ref_src[DARC_REF_VSEL_LSB +:
                                                                   DARC_REF_VSEL_W]);  // R4
    // Internal reference runs for codes 01 and 11; output buffer only for 01
    assign ref_internal_enable_o  = state_reg.ref_src[DARC_REF_VSEL_LSB];  // R4
    assign ref_output_enable_o    = state_reg.ref_out_en;  // R4
    assign ch_zero_filter_res_code_o = state_reg.ch0_filter[DARC_FILT_W-1:0];  // R13
    // Only the six defined resistor codes are flagged as valid
    assign ch_zero_filter_code_valid_o = state_reg.filt_valid;  // R14
    assign background_crc_enable_o = state_reg.fault_cfg[DARC_CFG_CRC_EN_BIT];  // R10
    assign thermal_shutdown_o     = state_reg.tsd;
    assign alarm_n_out_o          = state_reg.alarm_out;
    assign alarm_n_oe_n_o         = state_reg.alarm_oe_n;

endmodule : darc_regs

// *** darc_regs_assertions.sv ***
// Concurrent checks for the configuration register bank.
// Assumes it is bound to darc_regs and sees only that module's ports.
`timescale 1ns/100ps
module darc_regs_assertions
    import darc_pkg::*;
(
    input wire logic                        clock_i,
    input wire logic                        resetn_i,
    input wire logic [DARC_ADDR_W-1:0]      avs_address_i,
    input wire logic                        avs_read_i,
    input wire logic                        avs_write_i,
    input wire logic [31:0]                 avs_writedata_i,
    input wire logic [3:0]                  avs_byteenable_i,
    input wire logic [31:0]                 avs_readdata_o,
    input wire logic                        avs_waitrequest_o,
    input wire logic                        crc_error_i,
    input wire logic                        ref_resistor_fault_i,
    input wire logic                        ch_zero_negative_i,
    input wire logic                        over_temp_fault_i,
    input wire logic                        over_temp_warning_i,
    input wire logic [DARC_CH5_SCALE_W-1:0] ch_five_scale_factor_o,
    input wire logic                        ch_five_range_select_o,
    input wire logic                        ref_external_resistor_o,
    input wire darc_vref_t                  ref_voltage_select_o,
    input wire logic                        ref_internal_enable_o,
    input wire logic                        ref_output_enable_o,
    input wire logic                        thermal_shutdown_o,
    input wire logic                        alarm_n_out_o,
    input wire logic                        alarm_n_oe_n_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    // Bus steps and a quiet fault period
    sequence s_req_wait;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    sequence s_wr(logic [7:0] a);
        avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0] && avs_address_i == a;
    endsequence
    sequence s_quiet;
        !(crc_error_i || ref_resistor_fault_i || ch_zero_negative_i || over_temp_fault_i
          || over_temp_warning_i) [*6];
    endsequence

    a_wait_answer: assert property (s_req_wait |=> !avs_waitrequest_o)
        else $error("request not answered after one wait cycle");
    a_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    a_read_upper: assert property (avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_ch5_write: assert property (s_wr(8'h68) |=> {ch_five_scale_factor_o, ch_five_range_select_o}
        == {$past(avs_writedata_i[7:2]), $past(avs_writedata_i[0])})
        else $error("channel 5 fields do not follow write");
    a_ref_write: assert property (s_wr(8'h6C) |=> {ref_external_resistor_o, ref_voltage_select_o}
        == $past(avs_writedata_i[2:0]))
        else $error("reference fields do not follow write");
    a_vref_decode: assert property (ref_output_enable_o == (ref_voltage_select_o == DARC_VREF_INT_OUT_ON)
        && ref_internal_enable_o == ref_voltage_select_o[0])
        else $error("reference scheme decode wrong");
    a_tsd_quiet: assert property (!over_temp_fault_i [*6] |-> !thermal_shutdown_o)
        else $error("thermal shutdown without over-temperature");
    a_alarm_quiet: assert property (s_quiet |-> (alarm_n_out_o || alarm_n_oe_n_o))
        else $error("alarm active with no condition present");
    a_pin_mode: assert property (!(alarm_n_out_o && alarm_n_oe_n_o))
        else $error("alarm pin in undefined drive state");
endmodule : darc_regs_assertions

bind darc_regs darc_regs_assertions chk_u (.*);

// *** darc_regs_tb.sv ***
// Self-checking bench for the configuration register bank.
// Assumes darc_regs with its checker bound; bus reads are checked from a queue.
`timescale 1ns/100ps
module darc_regs_tb;
    import darc_pkg::*;
    logic        clock_i, resetn_i, avs_read_i, avs_write_i, avs_waitrequest_o;
    logic [7:0]  avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, d;
    logic [3:0]  avs_byteenable_i, ch_zero_filter_res_code_o;
    logic        crc_error_i, ref_resistor_fault_i, ch_zero_negative_i;
    logic        over_temp_fault_i, over_temp_warning_i, ch_five_range_select_o;
    logic        ref_external_resistor_o, ref_internal_enable_o, ref_output_enable_o;
    logic        ch_zero_filter_code_valid_o, background_crc_enable_o, thermal_shutdown_o;
    logic        alarm_n_out_o, alarm_n_oe_n_o;
    logic [5:0]  ch_five_scale_factor_o;
    darc_vref_t  ref_voltage_select_o;
    logic [31:0] rexp_q[$];
    int          failures, samples_checked, seed, i, k;
    int          mbit[5] = '{7, 6, 5, 4, 3}; // Mask bit per fault position

    darc_regs dut_u (.*);

    // Clock and time-zero values
    initial begin
        clock_i = 0;
        forever #10 clock_i = ~clock_i;
    end

    task automatic chk_read(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch t=%0t read %h expected %h", $time, got, exp);
        end
    endtask : chk_read

    task automatic chk_port(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch t=%0t port %h expected %h", $time, got, exp);
        end
    endtask : chk_port

    // Holds the request until waitrequest is sampled low
    task automatic bus_op(input logic rd, input logic [7:0] a, input logic [31:0] wd,
                          input logic [3:0] be);
        @(posedge clock_i);
        avs_address_i <= a;
        avs_writedata_i <= wd;
        avs_byteenable_i <= be;
        avs_read_i <= rd;
        avs_write_i <= !rd;
        do begin
            @(posedge clock_i);
        end while (avs_waitrequest_o !== 1'b0);
        avs_read_i <= 0;
        avs_write_i <= 0;
    endtask : bus_op

    task automatic bus_read(input logic [7:0] a, input logic [31:0] exp);
        rexp_q.push_back(exp);
        bus_op(1, a, 0, 4'hF);
    endtask : bus_read

    task automatic settle(input int n);
        repeat (n) @(posedge clock_i);
        @(negedge clock_i);
    endtask : settle

    task automatic set_flt(input logic [4:0] f);
        crc_error_i <= f[DARC_FLT_CRC];
        ref_resistor_fault_i <= f[DARC_FLT_RES];
        ch_zero_negative_i <= f[DARC_FLT_NEG];
        over_temp_fault_i <= f[DARC_FLT_OT];
        over_temp_warning_i <= f[DARC_FLT_WARN];
    endtask : set_flt

    task automatic summarize;
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize

    // Read results compared against the oldest note
    always @(posedge clock_i) begin
        if (avs_read_i && avs_waitrequest_o === 1'b0)
            chk_read(avs_readdata_o, rexp_q.pop_front());
    end

    // Watchdog
    initial begin
        #400000;
        failures++;
        summarize();
    end

    // Main sequence
    initial begin
        seed = 32'h6aa5;
        {resetn_i, avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
        avs_byteenable_i = 4'hF;
        {crc_error_i, ref_resistor_fault_i, ch_zero_negative_i} = '0;
        {over_temp_fault_i, over_temp_warning_i} = '0;
        repeat (6) @(posedge clock_i);
        resetn_i <= 1;
        bus_read(8'h68, 32'h00);
        bus_read(8'h6C, 32'h00);
        bus_read(8'h70, 32'h06);
        bus_read(8'h74, 32'h00);
        settle(1);
        chk_port({background_crc_enable_o, alarm_n_out_o, alarm_n_oe_n_o}, 8'h06);
        $display("test reset values done");
        for (i = 0; i < 4; i++) begin
            d = $random(seed);
            bus_op(0, 8'h68, d, 4'hF);
            bus_op(0, 8'h6C, d, 4'hF);
            bus_op(0, 8'h74, d, 4'hF);
            bus_op(0, 8'h68, ~d, 4'h0);
            settle(0);
            chk_port({ch_five_scale_factor_o, 1'b0, ch_five_range_select_o}, d[7:0] & 8'hFD);
            chk_port({ref_external_resistor_o, ref_voltage_select_o}, d[2:0]);
            chk_port(ch_zero_filter_res_code_o, d[3:0]);
            bus_read(8'h68, d[7:0] & 8'hFD);
            bus_read(8'h6C, d[7:0] & 8'h07);
            bus_read(8'h74, d[7:0] & 8'h0F);
            bus_read(8'h78, 32'h0);
            bus_read(8'h69, 32'h0);
        end
        $display("test register access done");
        // All eight fault config bits writable, then a mid-run reset restores defaults
        bus_op(0, 8'h70, 32'hF9, 4'hF);
        bus_read(8'h70, 32'hF9);
        @(posedge clock_i);
        resetn_i <= 0;
        repeat (2) @(posedge clock_i);
        resetn_i <= 1;
        bus_read(8'h68, 32'h00);
        bus_read(8'h6C, 32'h00);
        bus_read(8'h70, 32'h06);
        bus_read(8'h74, 32'h00);
        settle(0);
        chk_port({ref_output_enable_o, ch_zero_filter_code_valid_o}, 8'h01);
        $display("test mid-run reset done");
        for (k = 0; k < 16; k++) begin
            bus_op(0, 8'h6C, k, 4'hF);
            bus_op(0, 8'h74, k, 4'hF);
            settle(0);
            chk_port({ref_output_enable_o, ref_internal_enable_o}, {k[1:0] == 2'h1, k[0]});
            chk_port(ch_zero_filter_code_valid_o, k == 0 || (k >= 5 && k <= 9));
        end
        $display("test code decode done");
        for (k = 0; k < 5; k++) begin
            bus_op(0, 8'h70, 8'h06 | k[0], 4'hF);
            set_flt(5'h01 << k);
            settle(6);
            chk_port({alarm_n_out_o, alarm_n_oe_n_o}, 8'h0);
            chk_port(thermal_shutdown_o, k == DARC_FLT_OT);
            bus_op(0, 8'h70, (8'h06 | k[0]) | (8'h01 << mbit[k]), 4'hF);
            settle(2);
            chk_port({alarm_n_out_o, alarm_n_oe_n_o}, k[0] ? 8'h1 : 8'h2);
            set_flt(5'h00);
        end
        bus_op(0, 8'h70, 8'h10, 4'hF);
        set_flt(5'h09);
        settle(6);
        chk_port({background_crc_enable_o, thermal_shutdown_o, alarm_n_out_o}, 8'h1);
        set_flt(5'h00);
        $display("test alarm masks done");
        settle(2);
        summarize();
    end
endmodule : darc_regs_tb
